// ---- core/amr_cfg.svh ----
`ifndef AMR_CFG_SVH
`define AMR_CFG_SVH
// Register byte addresses
`define AMR_ADDR_CTRL 8'h00
`define AMR_ADDR_VOL 8'h04
`define AMR_ADDR_STAT 8'h08
`define AMR_ADDR_ID 8'h0C
// Control fields
`define AMR_CTRL_INSEL_LSB 0
`define AMR_CTRL_MON_LSB 2
`define AMR_CTRL_FORCE_MC_BIT 4
`define AMR_CTRL_MC2ST_BIT 5
`define AMR_CTRL_PAIR_LSB 6
`define AMR_CTRL_RESET 32'h0000_0000
// Volume fields
`define AMR_VOL_COARSE_LSB 0
`define AMR_VOL_FINE_LSB 8
`define AMR_VOL_RESET 32'h0000_0000
// Refresh interval of the rate/format status
`define AMR_REFRESH_MS 500
`define AMR_CLK_KHZ 40000
`define AMR_REFRESH_CYC (`AMR_REFRESH_MS * `AMR_CLK_KHZ)
// Identity value, arbitrary
`define AMR_ID_VALUE 32'h0A0D_0001
`endif

// ---- core/amr_pkg.sv ----
`default_nettype none
package amr_pkg;
  // Monitor setting
  typedef enum logic [1:0] {
    AMR_MON_AUTO = 2'b00,
    AMR_MON_PLAY = 2'b01,
    AMR_MON_INPUT = 2'b10
  } amr_mon_t;
  // Input format as classified
  typedef enum logic [1:0] {
    AMR_FMT_NONE = 2'b00,
    AMR_FMT_STEREO = 2'b01,
    AMR_FMT_MULTI = 2'b10
  } amr_fmt_t;
  // One eight-channel frame; stereo uses slots 0 and 1
  typedef struct packed {
    logic multi;
    logic [7:0][23:0] ch;
  } amr_frame_t;
  // Receiver status from the input decoders
  typedef struct packed {
    logic locked;
    logic err;
    logic rate_ok;
    logic multi;
    logic [2:0] rate;
  } amr_rxstat_t;
endpackage
`default_nettype wire

// ---- core/amr_router.sv ----
// ====================================================================
// Overview of operation
// - Drive all three digital outputs identically in stereo output
// - Accept any source, ignore channel status
// - Analogue samples come from digital output
// - Error flag while input bad or absent
// - Report out-of-range and lock-lost status
// - Refresh rate and format every 0.5s
// - Classify stereo versus eight-channel input
// - Automatic: monitor input only while recording
// - Play-only: never route input out
// - Input mode: monitor whenever playback idle
// - Input selection follows immediately
// - Multichannel output: analogue plays selected pair
// - Coarse 6 dB steps plus fine attenuation
// - Force-multichannel makes eight-channel output unless multichannel-to-stereo set
// - Multichannel input channels 1,2 recorded
// - Stereo playback lands in tracks 1,2
// - Stereo input duplicated into four pairs
// - Multichannel-to-stereo forces stereo output
// - Pair select picks pair for stereo
// - Record and playback paths run independently
// - Multichannel output disables coax and balanced
`timescale 1ns/1ps
`default_nettype none
`include "amr_cfg.svh"

module amr_router #(
  parameter int unsigned REFRESH_CYC = `AMR_REFRESH_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transport state from the host side, same clock
  input wire logic rec_active,
  input wire logic play_active,
  // Receiver status of the four inputs, from decoder domain
  input wire amr_pkg::amr_rxstat_t [3:0] rx_stat,
  // Received frames of the four inputs, same clock
  input wire amr_pkg::amr_frame_t [3:0] rx_frame,
  input wire logic rx_frame_stb,
  // Host playback frame
  input wire amr_pkg::amr_frame_t play_frame,
  input wire logic play_frame_stb,
  // Outputs
  output amr_pkg::amr_frame_t tx_frame,
  output logic tx_frame_stb,
  output logic opt_out_en,
  output logic coax_out_en,
  output logic xlr_out_en,
  output logic [1:0][23:0] rec_sample,
  output logic rec_stb,
  output logic [1:0][23:0] dac_sample,
  output logic dac_stb,
  output logic err_led
);

  // ==================================================================
  // Registers and signals
  logic [31:0] ctrl_q; // Control register
  logic [31:0] vol_q; // Volume register
  logic [1:0] insel_q; // Applied input select
  amr_pkg::amr_mon_t mon_q; // Applied monitor setting
  logic force_mc_q; // Applied force-multichannel
  logic mc2st_q; // Applied multichannel-to-stereo
  logic [1:0] pair_q; // Applied pair select
  amr_pkg::amr_rxstat_t [3:0] sync1_q; // First synchroniser stage
  amr_pkg::amr_rxstat_t [3:0] sync2_q; // Second synchroniser stage
  amr_pkg::amr_rxstat_t cur_stat; // Status of active input
  logic [31:0] ref_cnt_q; // Refresh counter
  logic [2:0] rep_rate_q; // Reported rate
  amr_pkg::amr_fmt_t rep_fmt_q; // Reported format
  logic rep_nolock_q; // Reported lock lost
  logic rep_oor_q; // Reported out of range
  logic route_in; // Input goes to outputs
  logic out_multi; // Output in eight-channel format
  logic frame_stb; // Frame strobe of the selected source
  amr_pkg::amr_frame_t src_frame; // Chosen source frame
  amr_pkg::amr_frame_t out_d; // Formatted output frame
  logic [1:0][23:0] pair_smp; // Pair for the analogue path
  logic [1:0][23:0] att_smp; // Attenuated pair
  logic aw_hold_q; // Write address taken
  logic w_hold_q; // Write data taken
  logic [7:0] awaddr_q; // Latched write address
  logic [31:0] wdata_q; // Latched write data
  logic [3:0] wstrb_q; // Latched strobes

  // ==================================================================
  // AXI4-Lite write channel
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign s_axi_bresp = 2'h0;

  // Address and data capture, either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_hold_q && w_hold_q) begin
        // Both halves present: commit and answer
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes with byte strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `AMR_CTRL_RESET;
      vol_q <= `AMR_VOL_RESET;
    end else if (clk_en && aw_hold_q && w_hold_q) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_q[b]) begin
          if (awaddr_q[7:2] == 6'(`AMR_ADDR_CTRL >> 2)) begin
            ctrl_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
          end
          if (awaddr_q[7:2] == 6'(`AMR_ADDR_VOL >> 2)) begin
            vol_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
          end
        end
      end
    end
  end

  // ==================================================================
  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'h0;

  // Read data, unmapped addresses return zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        case (s_axi_araddr[7:2])
          6'(`AMR_ADDR_CTRL >> 2): s_axi_rdata <= ctrl_q;
          6'(`AMR_ADDR_VOL >> 2): s_axi_rdata <= vol_q;
          6'(`AMR_ADDR_STAT >> 2): begin
            // Status snapshot
            s_axi_rdata <= {24'h00_0000, err_led, rep_oor_q, rep_nolock_q,
              rep_fmt_q, rep_rate_q};
          end
          6'(`AMR_ADDR_ID >> 2): s_axi_rdata <= `AMR_ID_VALUE;
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==================================================================
  // Input status
  // Two-stage synchroniser for the decoder status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (clk_en) begin
      sync1_q <= rx_stat;
      sync2_q <= sync1_q;
    end
  end

  // Input choice acts directly on status
  assign cur_stat = sync2_q[insel_q];
  // Error lamp follows the active input at once
  assign err_led = !cur_stat.locked || cur_stat.err;

  // Periodic status refresh
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_cnt_q <= 32'h0000_0000;
      rep_rate_q <= 3'h0;
      rep_fmt_q <= amr_pkg::AMR_FMT_NONE;
      rep_nolock_q <= 1'b1;
      rep_oor_q <= 1'b0;
    end else if (clk_en) begin
      if (ref_cnt_q >= REFRESH_CYC - 1) begin
        ref_cnt_q <= 32'h0000_0000;
        rep_rate_q <= cur_stat.rate;
        rep_nolock_q <= !cur_stat.locked || cur_stat.err;
        rep_oor_q <= cur_stat.locked && !cur_stat.rate_ok;
        if (!cur_stat.locked || cur_stat.err) begin
          rep_fmt_q <= amr_pkg::AMR_FMT_NONE;
        end else if (cur_stat.multi) begin
          rep_fmt_q <= amr_pkg::AMR_FMT_MULTI;
        end else begin
          rep_fmt_q <= amr_pkg::AMR_FMT_STEREO;
        end
      end else begin
        ref_cnt_q <= ref_cnt_q + 32'h0000_0001;
      end
    end
  end

  // ==================================================================
  // Routing
  // Settings latched each cycle, except while tx_frame_stb is high without a new frame strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      insel_q <= 2'h0;
      mon_q <= amr_pkg::AMR_MON_AUTO;
      force_mc_q <= 1'b0;
      mc2st_q <= 1'b0;
      pair_q <= 2'h0;
    end else if (clk_en && (frame_stb || !tx_frame_stb)) begin
      insel_q <= ctrl_q[`AMR_CTRL_INSEL_LSB +: 2];
      case (ctrl_q[`AMR_CTRL_MON_LSB +: 2])
        2'h1: mon_q <= amr_pkg::AMR_MON_PLAY;
        2'h2: mon_q <= amr_pkg::AMR_MON_INPUT;
        default: mon_q <= amr_pkg::AMR_MON_AUTO;
      endcase
      force_mc_q <= ctrl_q[`AMR_CTRL_FORCE_MC_BIT];
      mc2st_q <= ctrl_q[`AMR_CTRL_MC2ST_BIT];
      pair_q <= ctrl_q[`AMR_CTRL_PAIR_LSB +: 2];
    end
  end

  // Monitor decision
  always_comb begin
    case (mon_q)
      amr_pkg::AMR_MON_AUTO: route_in = rec_active;
      amr_pkg::AMR_MON_PLAY: route_in = 1'b0;
      amr_pkg::AMR_MON_INPUT: route_in = !play_active;
      default: route_in = 1'b0;
    endcase
  end

  // Source and its frame strobe
  assign src_frame = route_in ? rx_frame[insel_q] : play_frame;
  assign frame_stb = route_in ? rx_frame_stb : play_frame_stb;

  // Output format: stereo wins when conversion asked
  assign out_multi = !mc2st_q && (force_mc_q || src_frame.multi);

  // Output frame formatting; channel status never copied
  always_comb begin
    out_d = '0;
    out_d.multi = out_multi;
    if (mc2st_q && src_frame.multi) begin
      // Selected pair to stereo
      out_d.ch[0] = src_frame.ch[{pair_q, 1'b0}];
      out_d.ch[1] = src_frame.ch[{pair_q, 1'b1}];
    end else if (out_multi && !src_frame.multi) begin
      if (route_in) begin
        // Stereo input copied into every pair
        for (int p = 0; p < 4; p++) begin
          out_d.ch[2*p] = src_frame.ch[0];
          out_d.ch[2*p+1] = src_frame.ch[1];
        end
      end else begin
        // Stereo playback on tracks one and two
        out_d.ch[0] = src_frame.ch[0];
        out_d.ch[1] = src_frame.ch[1];
      end
    end else begin
      out_d.ch = src_frame.ch;
    end
  end

  // Registered output frame, one copy for all connectors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_frame <= '0;
      tx_frame_stb <= 1'b0;
    end else if (clk_en) begin
      tx_frame_stb <= frame_stb;
      if (frame_stb) begin
        tx_frame <= out_d;
      end
    end
  end

  // Connector enables; coax and balanced off in multichannel
  assign opt_out_en = 1'b1;
  assign coax_out_en = !tx_frame.multi;
  assign xlr_out_en = !tx_frame.multi;

  // ==================================================================
  // Record path, independent of playback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rec_sample <= '0;
      rec_stb <= 1'b0;
    end else if (clk_en) begin
      rec_stb <= rx_frame_stb;
      if (rx_frame_stb) begin
        // Channels 1 and 2 become left and right
        rec_sample[0] <= rx_frame[insel_q].ch[0];
        rec_sample[1] <= rx_frame[insel_q].ch[1];
      end
    end
  end

  // ==================================================================
  // Analogue path taken from the digital output
  always_comb begin
    if (tx_frame.multi) begin
      pair_smp[0] = tx_frame.ch[{pair_q, 1'b0}];
      pair_smp[1] = tx_frame.ch[{pair_q, 1'b1}];
    end else begin
      pair_smp[0] = tx_frame.ch[0];
      pair_smp[1] = tx_frame.ch[1];
    end
  end

  // Coarse shift by 6 dB steps, then fine scale
  always_comb begin
    logic signed [23:0] s;
    logic signed [32:0] m;
    s = '0;
    m = '0;
    for (int c = 0; c < 2; c++) begin
      s = $signed(pair_smp[c]) >>> vol_q[`AMR_VOL_COARSE_LSB +: 2];
      m = s * $signed({1'b0, 8'hFF - vol_q[`AMR_VOL_FINE_LSB +: 8]});
      att_smp[c] = m[31:8];
    end
  end

  // Registered DAC samples
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_sample <= '0;
      dac_stb <= 1'b0;
    end else if (clk_en) begin
      dac_stb <= tx_frame_stb;
      if (tx_frame_stb) begin
        dac_sample <= att_smp;
      end
    end
  end

endmodule // amr_router
`default_nettype wire

// ---- verif/amr_router_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port-level checks on routing strobes, enables and bus answers
module amr_router_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic rx_frame_stb,
  input wire logic play_frame_stb,
  input wire amr_pkg::amr_frame_t tx_frame,
  input wire logic tx_frame_stb,
  input wire logic opt_out_en,
  input wire logic coax_out_en,
  input wire logic xlr_out_en,
  input wire logic rec_stb,
  input wire logic dac_stb
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Output frame, then its analogue copy one cycle on
  sequence s_tx_then_dac;
    tx_frame_stb ##1 dac_stb;
  endsequence
  chk_frame_path: assert property ((rx_frame_stb && play_frame_stb) |=> s_tx_then_dac)
    else $error("frame strobe did not reach outputs");
  chk_tx_cause: assert property (tx_frame_stb |-> $past(rx_frame_stb || play_frame_stb))
    else $error("output frame without source frame");
  chk_dac_cause: assert property (dac_stb |-> $past(tx_frame_stb))
    else $error("analogue sample without output frame");
  chk_rec_follow: assert property (rx_frame_stb |=> rec_stb)
    else $error("record strobe missing");
  chk_enable_split: assert property (coax_out_en == !tx_frame.multi)
    else $error("coax enable wrong for output format");
  chk_out_parallel: assert property (opt_out_en && (xlr_out_en == coax_out_en))
    else $error("outputs not driven in parallel");
  chk_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("write response not okay");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
endmodule // amr_router_checker
`default_nettype wire

// ---- verif/amr_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far-side equipment: input 0 unlocked, 1 and 2 stereo, 3 multichannel
module amr_far_end (
  output var amr_pkg::amr_rxstat_t [3:0] rx_stat,
  output var amr_pkg::amr_frame_t [3:0] rx_frame
);
  // Status and frame content per input; unused stereo slots carry junk
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rx_stat[i].locked = (i != 0);
      rx_stat[i].err = 1'b0;
      rx_stat[i].rate_ok = (i != 2);
      rx_stat[i].multi = (i == 3);
      rx_stat[i].rate = 3'(i + 1);
      rx_frame[i].multi = (i == 3);
      for (int k = 0; k < 8; k++) begin
        rx_frame[i].ch[k] = (i == 3 || k < 2) ? (24'hA00000 | 24'(i * 256 + k)) : 24'hFFFFFF;
      end
    end
  end
endmodule // amr_far_end
`default_nettype wire

// ---- verif/amr_router_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "amr_cfg.svh"
// ==========================================================
// Register-driven routing scenarios
module amr_router_tb;
  logic aclk = 0, aresetn = 0, rec = 0, play = 0, rstb = 0, pstb = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, v;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  amr_pkg::amr_rxstat_t [3:0] rx_stat;
  amr_pkg::amr_frame_t [3:0] rx_frame;
  amr_pkg::amr_frame_t play_frame, tx_frame;
  logic tx_stb, opt_en, coax_en, xlr_en, rec_stb, dac_stb, err_led;
  logic [1:0][23:0] rec_sample, dac_sample;
  int n_errors = 0, n_checks = 0, cyc = 0;
  // Clock and playback content
  initial forever #12.5 aclk = ~aclk;
  always_comb begin
    play_frame.multi = 1'b0;
    for (int k = 0; k < 8; k++) play_frame.ch[k] = 24'hB00000 | 24'(k);
  end
  amr_far_end far_u (.rx_stat(rx_stat), .rx_frame(rx_frame));
  amr_router #(.REFRESH_CYC(50)) dut_u (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rec_active(rec), .play_active(play), .rx_stat(rx_stat), .rx_frame(rx_frame),
    .rx_frame_stb(rstb), .play_frame(play_frame), .play_frame_stb(pstb),
    .tx_frame(tx_frame), .tx_frame_stb(tx_stb), .opt_out_en(opt_en), .coax_out_en(coax_en),
    .xlr_out_en(xlr_en), .rec_sample(rec_sample), .rec_stb(rec_stb),
    .dac_sample(dac_sample), .dac_stb(dac_stb), .err_led(err_led));
  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  task results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [23:0] inp(input int i, input int k);
    return 24'hA00000 | 24'(i * 256 + k);
  endfunction
  // Expected analogue sample: coarse arithmetic shift, then gain (255 - fine) / 256
  function automatic logic [23:0] att(input logic [23:0] x, input int c, input int f);
    int s;
    s = $signed({{8{x[23]}}, x}) >>> c;
    return 24'((s * (255 - f)) >>> 8);
  endfunction
  function automatic logic [31:0] ctl(input int s, input int m, input int f, input int c, input int p);
    return 32'(s % 4) | 32'((m % 4) << 2) | 32'((f % 2) << 4) | 32'((c % 2) << 5) | 32'((p % 4) << 6);
  endfunction
  // Write: offer address and data together, release each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready; tw = wvalid && wready; tb = bvalid && bready;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end
    bready <= 0;
  endtask
  // Read: data taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ta, tr;
    tr = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready; tr = rvalid && rready; d = rdata;
      @(posedge aclk);
      if (ta) arvalid <= 0;
    end
    rready <= 0;
  endtask
  // Two frames: first lets new settings land, second is checked
  task automatic frame(input logic r, input logic p);
    int n;
    repeat (2) begin
      @(posedge aclk);
      rec <= r; play <= p; rstb <= 1; pstb <= 1;
      @(posedge aclk);
      rstb <= 0; pstb <= 0;
      n = 0;
      do begin @(negedge aclk); n++; end while (tx_stb !== 1'b1 && n < 4);
    end
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(`AMR_ADDR_ID, v); chk("id", v, `AMR_ID_VALUE);
    chk("rresp", rresp, 0);
    rd(`AMR_ADDR_CTRL, v); chk("ctrl_reset", v, `AMR_CTRL_RESET);
    rd(8'h10, v); chk("unmapped", v, 32'h0000_0000);
    wr(`AMR_ADDR_CTRL, ctl(1, 0, 0, 0, 0));
    rd(`AMR_ADDR_CTRL, v); chk("ctrl", v, ctl(1, 0, 0, 0, 0));
    frame(1, 0); chk("auto_rec", tx_frame.ch[0], inp(1, 0));
    chk("rec_r", rec_sample[1], inp(1, 1));
    frame(0, 0); chk("auto_idle", tx_frame.ch[0], 24'hB00000);
    wr(`AMR_ADDR_CTRL, ctl(1, 3, 0, 0, 0));
    frame(1, 1); chk("auto_spare", tx_frame.ch[0], inp(1, 0));
    wr(`AMR_ADDR_CTRL, ctl(1, 1, 0, 0, 0));
    frame(1, 0); chk("play_only", tx_frame.ch[1], 24'hB00001);
    wr(`AMR_ADDR_CTRL, ctl(1, 2, 0, 0, 0));
    frame(0, 0); chk("input_mon", tx_frame.ch[0], inp(1, 0));
    wr(`AMR_ADDR_CTRL, ctl(2, 2, 0, 0, 0));
    frame(0, 0); chk("new_sel", tx_frame.ch[1], inp(2, 1));
    frame(0, 1); chk("input_play", tx_frame.ch[0], 24'hB00000);
    wr(`AMR_ADDR_CTRL, ctl(1, 2, 1, 0, 0));
    frame(0, 0); chk("force_fmt", tx_frame.multi, 1);
    for (int p = 0; p < 4; p++) begin
      chk("dup_l", tx_frame.ch[2 * p], inp(1, 0));
      chk("dup_r", tx_frame.ch[2 * p + 1], inp(1, 1));
    end
    chk("coax_off", coax_en, 0);
    chk("xlr_off", xlr_en, 0);
    wr(`AMR_ADDR_CTRL, ctl(1, 1, 1, 0, 0));
    frame(0, 1); chk("play_mc", tx_frame.multi, 1);
    chk("play_t1", tx_frame.ch[0], 24'hB00000);
    chk("play_t2", tx_frame.ch[1], 24'hB00001);
    wr(`AMR_ADDR_CTRL, ctl(3, 2, 1, 1, 2));
    frame(0, 0); chk("m2s_fmt", tx_frame.multi, 0);
    chk("pair_l", tx_frame.ch[0], inp(3, 4));
    chk("pair_r", tx_frame.ch[1], inp(3, 5));
    chk("coax_on", coax_en, 1);
    chk("rec_mc", rec_sample[0], inp(3, 0));
    wr(`AMR_ADDR_VOL, 32'h0000_FF00);
    frame(0, 0);
    repeat (2) @(negedge aclk);
    chk("dac_mute", dac_sample[0], 0);
    wr(`AMR_ADDR_VOL, 32'h0000_0001);
    wr(`AMR_ADDR_CTRL, ctl(3, 2, 0, 0, 1));
    frame(0, 0);
    repeat (2) @(negedge aclk);
    chk("dac_pair_l", dac_sample[0], att(inp(3, 2), 1, 0));
    chk("dac_pair_r", dac_sample[1], att(inp(3, 3), 1, 0));
    wr(`AMR_ADDR_CTRL, ctl(0, 2, 0, 0, 0));
    repeat (120) @(posedge aclk);
    chk("led_on", err_led, 1);
    rd(`AMR_ADDR_STAT, v); chk("nolock", v[5], 1);
    wr(`AMR_ADDR_CTRL, ctl(1, 2, 0, 0, 0));
    repeat (120) @(posedge aclk);
    chk("led_off", err_led, 0);
    rd(`AMR_ADDR_STAT, v); chk("stat_st", v[5:0], 6'h0A);
    wr(`AMR_ADDR_CTRL, ctl(2, 2, 0, 0, 0));
    repeat (120) @(posedge aclk);
    rd(`AMR_ADDR_STAT, v); chk("range", v[6], 1);
    wr(`AMR_ADDR_CTRL, ctl(3, 2, 0, 0, 0));
    repeat (120) @(posedge aclk);
    rd(`AMR_ADDR_STAT, v); chk("stat_mc", v[4:3], 2'h2);
    results();
  end
endmodule // amr_router_tb
bind amr_router amr_router_checker chk_u (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .rx_frame_stb, .play_frame_stb,
  .tx_frame, .tx_frame_stb, .opt_out_en, .coax_out_en, .xlr_out_en, .rec_stb, .dac_stb);
`default_nettype wire
